// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tcg_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        timer_in;
  logic        timer_out;
  logic        output_function_on;
  logic        timer_irq;
  int          errors = 0;
  int          checks = 0;
  int          irq_n = 0;
  int          base;
  logic [7:0]  q;
  logic [15:0] c0;
  logic [15:0] c1;
  logic [15:0] cap;

  tcg_timer uut (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_in(timer_in), .timer_out(timer_out),
    .output_function_on(output_function_on), .timer_irq(timer_irq)
  );
  tcg_pin_src src (.mclk(mclk), .pin(timer_in));

  always #2 mclk = ~mclk;
  always @(posedge mclk) if (timer_irq === 1'b1) irq_n <= irq_n + 1;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic close_out;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      errors++;
      close_out;
    end
  endtask

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  task automatic rd16(input logic [2:0] idx, output logic [15:0] v);
    bus(1'b0, idx, 8'h00, 4'h0);
    v[15:8] = q;
    bus(1'b0, idx + 3'h1, 8'h00, 4'h0);
    v[7:0] = q;
  endtask

  task automatic wait_irq(input int n, input int lim);
    int k;
    k = 0;
    while (irq_n < n && k < lim) begin
      @(posedge mclk);
      k++;
    end
    chk("irq count", 16'(n), 16'(irq_n));
    // a wait that ran out ends the run here
    if (irq_n < n) close_out;
  endtask

  function automatic logic [7:0] cw(input logic en, input logic pol, input tcg_mode_t m);
    return {en, pol, 3'h0, m};
  endfunction

  task automatic setup(input logic [7:0] ctl, input logic [15:0] st, input logic [15:0] rl);
    wr(IDX_TIMER_CONTROL, ctl);
    wr(IDX_COUNT_HIGH, st[15:8]);
    wr(IDX_COUNT_LOW, st[7:0]);
    wr(IDX_RELOAD_HIGH, rl[15:8]);
    wr(IDX_RELOAD_LOW, rl[7:0]);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] ex [8];
    ex = '{8'h00, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 3'(i), 8'h00, 4'h0);
      chk("reset value", {8'h00, ex[i]}, {8'h00, q});
    end
    wr(IDX_RELOAD_HIGH, 8'h12);
    rd16(IDX_RELOAD_HIGH, c0);
    chk("reload before low write", 16'hffff, c0);
    bus(1'b1, IDX_RELOAD_LOW, 8'h99, 4'h0);
    wr(IDX_RELOAD_LOW, 8'h34);
    rd16(IDX_RELOAD_HIGH, c0);
    chk("reload committed", 16'h1234, c0);
  endtask

  task automatic t_compare;
    setup(cw(1'b0, 1'b0, TCG_MODE_COMPARE), 16'hfff0, 16'hfff4);
    wr(IDX_PIN_CONFIG, 8'h01);
    // the write lands on the edge the task returns at; look one edge later
    @(posedge mclk);
    chk("output function", 16'h1, {15'h0, output_function_on});
    base = irq_n;
    wr(IDX_TIMER_CONTROL, cw(1'b1, 1'b0, TCG_MODE_COMPARE));
    wait_irq(base + 1, 60);
    chk("timer_out after match", 16'h1, {15'h0, timer_out});
    bus(1'b0, IDX_COUNT_HIGH, 8'h00, 4'h0);
    chk("count high after match", 16'h00ff, {8'h00, q});
    repeat (30) @(posedge mclk);
    bus(1'b0, IDX_COUNT_HIGH, 8'h00, 4'h0);
    chk("count high after wrap", 16'h0000, {8'h00, q});
    chk("irq total", 16'(base + 1), 16'(irq_n));
    // prescale exponent 3: one count per 8 clocks, match on the third tick
    setup(cw(1'b0, 1'b0, TCG_MODE_COMPARE) | 8'h18, 16'hfff0, 16'hfff2);
    base = irq_n;
    wr(IDX_TIMER_CONTROL, cw(1'b1, 1'b0, TCG_MODE_COMPARE) | 8'h18);
    repeat (20) @(posedge mclk);
    chk("no irq before third tick", 16'(base), 16'(irq_n));
    wait_irq(base + 1, 20);
    bus(1'b0, IDX_COUNT_HIGH, 8'h00, 4'h0);
    chk("count high divided", 16'h00ff, {8'h00, q});
  endtask

  task automatic t_gated;
    setup(cw(1'b0, 1'b1, TCG_MODE_GATED), 16'h0001, 16'h0010);
    wr(IDX_PIN_CONFIG, 8'h01);
    wr(IDX_TIMER_CONTROL, cw(1'b1, 1'b1, TCG_MODE_GATED));
    repeat (20) @(posedge mclk);
    rd16(IDX_COUNT_HIGH, c0);
    chk("count with gate idle", 16'h0001, c0);
    base = irq_n;
    src.drive(1'b1, 2);
    wait_irq(base + 1, 40);
    chk("timer_out at reload", 16'h1, {15'h0, timer_out});
    rd16(IDX_COUNT_HIGH, c0);
    chk("count restarted", 16'h1, 16'(c0 < 16'h0010));
    src.drive(1'b0, 2);
    wait_irq(base + 2, 12);
    bus(1'b0, IDX_PIN_CONFIG, 8'h00, 4'h0);
    chk("pin level", 16'h0, {15'h0, q[CFG_PIN_LEVEL_BIT]});
    rd16(IDX_COUNT_HIGH, c0);
    rd16(IDX_COUNT_HIGH, c1);
    chk("count frozen", c0, c1);
    bus(1'b0, IDX_COUNT_HIGH, 8'h00, 4'h0);
    wr(IDX_COUNT_LOW, ~c0[7:0]);
    bus(1'b0, IDX_COUNT_LOW, 8'h00, 4'h0);
    chk("latched low", {8'h00, c0[7:0]}, {8'h00, q});
    wr(IDX_TIMER_CONTROL, cw(1'b0, 1'b1, TCG_MODE_GATED));
    bus(1'b0, IDX_COUNT_LOW, 8'h00, 4'h0);
    chk("live low", {8'h00, ~c0[7:0]}, {8'h00, q});
  endtask

  task automatic t_capture;
    setup(cw(1'b0, 1'b0, TCG_MODE_CAPTURE), 16'h0001, 16'h0040);
    wr(IDX_CAPTURE_HIGH, 8'h00);
    wr(IDX_CAPTURE_LOW, 8'h00);
    base = irq_n;
    wr(IDX_TIMER_CONTROL, cw(1'b1, 1'b0, TCG_MODE_CAPTURE));
    wait_irq(base + 1, 100);
    rd16(IDX_CAPTURE_HIGH, cap);
    chk("capture after reload", 16'h0000, cap);
    src.drive(1'b1, 8);
    chk("no capture on rise", 16'(base + 1), 16'(irq_n));
    rd16(IDX_COUNT_HIGH, c0);
    src.drive(1'b0, 2);
    wait_irq(base + 2, 12);
    rd16(IDX_COUNT_HIGH, c1);
    rd16(IDX_CAPTURE_HIGH, cap);
    chk("capture window", 16'h1, 16'(cap >= c0 && cap <= c1));
    chk("count runs on", 16'h1, 16'(c1 > c0));
  endtask

  task automatic t_capcmp;
    setup(cw(1'b0, 1'b1, TCG_MODE_CAPCMP), 16'h0001, 16'h0080);
    base = irq_n;
    wr(IDX_TIMER_CONTROL, cw(1'b1, 1'b1, TCG_MODE_CAPCMP));
    repeat (20) @(posedge mclk);
    rd16(IDX_COUNT_HIGH, c0);
    chk("held before start", 16'h0001, c0);
    src.drive(1'b1, 4);
    src.drive(1'b0, 20);
    chk("no irq on start", 16'(base), 16'(irq_n));
    rd16(IDX_COUNT_HIGH, c0);
    src.drive(1'b1, 2);
    wait_irq(base + 1, 12);
    rd16(IDX_CAPTURE_HIGH, cap);
    chk("capcmp capture", 16'h1, 16'(cap >= c0 && cap <= c0 + 16'h0010));
    rd16(IDX_COUNT_HIGH, c1);
    chk("reload to one", 16'h1, 16'(c1 < c0));
    wait_irq(base + 2, 160);
    rd16(IDX_COUNT_HIGH, c1);
    chk("compare reload", 16'h1, 16'(c1 < 16'h0020));
    src.drive(1'b0, 2);
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_compare;
    t_gated;
    t_capture;
    t_capcmp;
    close_out;
  end
endmodule
`default_nettype wire

// >>> tcg_pin_src.sv
`timescale 1ns/10ps
`default_nettype none
module tcg_pin_src (
  input  wire logic mclk,
  output logic      pin
);
  initial pin = 1'b0;
  // a level is held two clocks or more, else the synchroniser may miss it
  task automatic drive(input logic lvl, input int hold);
    pin <= lvl;
    repeat (hold) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> tcg_pkg.sv
`default_nettype none
package tcg_pkg;
  // ------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [2:0] IDX_COUNT_HIGH    = 3'h0;
  localparam logic [2:0] IDX_COUNT_LOW     = 3'h1;
  localparam logic [2:0] IDX_RELOAD_HIGH   = 3'h2;
  localparam logic [2:0] IDX_RELOAD_LOW    = 3'h3;
  localparam logic [2:0] IDX_CAPTURE_HIGH  = 3'h4;
  localparam logic [2:0] IDX_CAPTURE_LOW   = 3'h5;
  localparam logic [2:0] IDX_PIN_CONFIG    = 3'h6;
  localparam logic [2:0] IDX_TIMER_CONTROL = 3'h7;

  // ------------------------------------------------------------
  // reset and restart values
  // ------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET   = 16'h0001;
  localparam logic [15:0] RELOAD_RESET  = 16'hffff;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;

  // ------------------------------------------------------------
  // field positions and limits
  // ------------------------------------------------------------
  localparam int CFG_OUT_FN_BIT    = 0;
  localparam int CFG_OUT_LEVEL_BIT = 1;
  localparam int CFG_PIN_LEVEL_BIT = 2;
  localparam int PRESCALE_MAX      = 7;

  typedef enum logic [2:0] {
    TCG_MODE_CAPTURE = 3'b000,
    TCG_MODE_COMPARE = 3'b001,
    TCG_MODE_GATED   = 3'b010,
    TCG_MODE_CAPCMP  = 3'b011
  } tcg_mode_t;

  // timer_control layout: enable, polarity, prescale exponent, mode
  typedef struct packed {
    logic       enable;
    logic       input_polarity_select;
    logic [2:0] prescale;
    tcg_mode_t  mode;
  } tcg_ctl_t;

  // synchronised input events
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tcg_pin_t;
endpackage
`default_nettype wire

// >>> tcg_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tcg_timer
  import tcg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        timer_in,
  output logic             timer_out,
  output logic             output_function_on,
  output logic             timer_irq
);
  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic        ack;
  logic        rd_first;
  logic        wr_go;
  logic [2:0]  idx;
  logic [7:0]  wd;
  tcg_ctl_t    ctl;
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] capture;
  logic [7:0]  reload_high_temp;
  logic [7:0]  low_hold;
  logic        out_fn;
  tcg_pin_t    pin;

  // one wait state: every access answers at the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign rd_first        = avs_read & ~ack;
  assign wr_go           = avs_write & ack & avs_byteenable[0];
  assign idx             = avs_address[4:2];
  assign wd              = avs_writedata[7:0];
  assign output_function_on = out_fn;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // read side effects happen once, in the first cycle of the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (rd_first) begin
      avs_readdata <= 32'h0;
      if (idx == IDX_COUNT_HIGH) begin
        avs_readdata[7:0] <= count[15:8];
      end else if (idx == IDX_COUNT_LOW) begin
        avs_readdata[7:0] <= ctl.enable ? low_hold : count[7:0];
      end else if (idx == IDX_RELOAD_HIGH) begin
        avs_readdata[7:0] <= reload[15:8];
      end else if (idx == IDX_RELOAD_LOW) begin
        avs_readdata[7:0] <= reload[7:0];
      end else if (idx == IDX_CAPTURE_HIGH) begin
        avs_readdata[7:0] <= capture[15:8];
      end else if (idx == IDX_CAPTURE_LOW) begin
        avs_readdata[7:0] <= capture[7:0];
      end else if (idx == IDX_PIN_CONFIG) begin
        avs_readdata[CFG_OUT_FN_BIT]    <= out_fn;
        avs_readdata[CFG_OUT_LEVEL_BIT] <= timer_out;
        avs_readdata[CFG_PIN_LEVEL_BIT] <= pin.level;
      end else begin
        avs_readdata[7:0] <= ctl;
      end
    end
  end

  // holding register only; reading never touches the counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_hold <= COUNT_RESET[7:0];
    end else if (rd_first && idx == IDX_COUNT_HIGH && ctl.enable) begin
      low_hold <= count[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl <= tcg_ctl_t'(CONTROL_RESET);
    end else if (wr_go && idx == IDX_TIMER_CONTROL) begin
      ctl <= tcg_ctl_t'(wd);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_fn <= 1'b0;
    end else if (wr_go && idx == IDX_PIN_CONFIG) begin
      out_fn <= wd[CFG_OUT_FN_BIT];
    end
  end

  // both reload bytes change together on the low byte write
  always_ff @(posedge mclk) begin
    if (rst) begin
      reload_high_temp <= RELOAD_RESET[15:8];
      reload           <= RELOAD_RESET;
    end else if (wr_go && idx == IDX_RELOAD_HIGH) begin
      reload_high_temp <= wd;
    end else if (wr_go && idx == IDX_RELOAD_LOW) begin
      reload <= {reload_high_temp, wd};
    end
  end

  // ------------------------------------------------------------
  // input pin and prescaler
  // ------------------------------------------------------------
  logic       in_s1;
  logic       in_s2;
  logic       in_s3;
  logic [6:0] div;
  logic       tick;

  always_ff @(posedge mclk) begin
    if (rst) begin
      in_s1 <= 1'b0;
      in_s2 <= 1'b0;
      in_s3 <= 1'b0;
    end else begin
      in_s1 <= timer_in;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end

  // one driver for the whole carrier: level, rise, fall
  assign pin = tcg_pin_t'({in_s2, in_s2 & ~in_s3, ~in_s2 & in_s3});

  // divider restarts while disabled so the first period is full length
  always_ff @(posedge mclk) begin
    if (rst || !ctl.enable) begin
      div <= 7'h00;
    end else if (tick) begin
      div <= 7'h00;
    end else begin
      div <= div + 7'h01;
    end
  end

  assign tick = ctl.enable &&
                (div == 7'((8'h01 << ctl.prescale) - 8'h01));

  // ------------------------------------------------------------
  // mode logic
  // ------------------------------------------------------------
  logic sel_edge;
  logic gate_on;
  logic gate_off;
  logic at_reload;
  logic started;
  logic cap_evt;
  logic match_evt;
  logic reload_evt;
  logic irq_evt;

  assign sel_edge  = ctl.input_polarity_select ? pin.rise : pin.fall;
  assign gate_on   = (pin.level == ctl.input_polarity_select);
  assign gate_off  = ctl.input_polarity_select ? pin.fall : pin.rise;
  assign at_reload = (count == reload);

  always_comb begin
    cap_evt    = 1'b0;
    match_evt  = 1'b0;
    reload_evt = 1'b0;
    irq_evt    = 1'b0;
    if (ctl.enable) begin
      case (ctl.mode)
        TCG_MODE_CAPTURE: begin
          cap_evt   = sel_edge;
          match_evt = tick & at_reload;
          irq_evt   = cap_evt | match_evt;
        end
        TCG_MODE_COMPARE: begin
          match_evt = tick & at_reload;
          irq_evt   = match_evt;
        end
        TCG_MODE_GATED: begin
          reload_evt = tick & gate_on & at_reload;
          irq_evt    = reload_evt | gate_off;
        end
        TCG_MODE_CAPCMP: begin
          cap_evt    = started & sel_edge;
          reload_evt = started & (sel_edge | (tick & at_reload));
          irq_evt    = reload_evt;
        end
        default: begin
          irq_evt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !ctl.enable) begin
      started <= 1'b0;
    end else if (ctl.mode == TCG_MODE_CAPCMP && sel_edge) begin
      started <= 1'b1;
    end
  end

  // software byte writes land directly; a count in flight is overwritten
  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= COUNT_RESET;
    end else if (wr_go && idx == IDX_COUNT_HIGH) begin
      count[15:8] <= wd;
    end else if (wr_go && idx == IDX_COUNT_LOW) begin
      count[7:0] <= wd;
    end else if (reload_evt) begin
      count <= COUNT_RESTART;
    end else if (tick && (ctl.mode != TCG_MODE_GATED || gate_on) &&
                 (ctl.mode != TCG_MODE_CAPCMP || started)) begin
      count <= count + 16'h0001;
    end
  end

  // a hardware capture wins over a software write in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      capture <= CAPTURE_RESET;
    end else if (cap_evt) begin
      capture <= count;
    end else if (wr_go && idx == IDX_CAPTURE_HIGH) begin
      capture[15:8] <= wd;
    end else if (wr_go && idx == IDX_CAPTURE_LOW) begin
      capture[7:0] <= wd;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_out <= 1'b0;
    end else if (out_fn && (reload_evt ||
                 (ctl.mode == TCG_MODE_COMPARE && match_evt))) begin
      timer_out <= ~timer_out;
    end else if (wr_go && idx == IDX_PIN_CONFIG && !ctl.enable) begin
      timer_out <= wd[CFG_OUT_LEVEL_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_evt;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic quiet;
  assign quiet = !(avs_write & ack);

  sequence s_reload_high_write;
    wr_go && idx == IDX_RELOAD_HIGH;
  endsequence
  sequence s_reload_low_idle;
    !(wr_go && idx == IDX_RELOAD_LOW);
  endsequence

  property p_capture_store;
    @(posedge mclk) disable iff (rst)
      (ctl.enable && ctl.mode == TCG_MODE_CAPTURE && sel_edge)
        |=> capture == $past(count) && timer_irq;
  endproperty
  a_capture_store: assert property (p_capture_store) else $error("capture missed");

  property p_capture_no_reload;
    @(posedge mclk) disable iff (rst)
      (ctl.enable && ctl.mode == TCG_MODE_CAPTURE && tick && quiet)
        |=> count == $past(count) + 16'h0001;
  endproperty
  a_capture_no_reload: assert property (p_capture_no_reload) else $error("count stalled");

  property p_compare_match;
    @(posedge mclk) disable iff (rst)
      (ctl.enable && ctl.mode == TCG_MODE_COMPARE && tick && at_reload && quiet)
        |=> timer_irq && count == $past(reload) + 16'h0001 &&
            (timer_out != $past(timer_out)) == $past(out_fn);
  endproperty
  a_compare_match: assert property (p_compare_match) else $error("compare match wrong");

  property p_gated_hold;
    @(posedge mclk) disable iff (rst)
      (ctl.enable && ctl.mode == TCG_MODE_GATED && !gate_on && quiet)
        |=> count == $past(count);
  endproperty
  a_gated_hold: assert property (p_gated_hold) else $error("gated count moved");

  property p_gated_off_irq;
    @(posedge mclk) disable iff (rst)
      (ctl.enable && ctl.mode == TCG_MODE_GATED && gate_off) |=> timer_irq;
  endproperty
  a_gated_off_irq: assert property (p_gated_off_irq) else $error("no gate irq");

  property p_capcmp_first;
    @(posedge mclk) disable iff (rst)
      (ctl.enable && ctl.mode == TCG_MODE_CAPCMP && !started && sel_edge)
        |=> !timer_irq && started;
  endproperty
  a_capcmp_first: assert property (p_capcmp_first) else $error("first edge irq");

  property p_capcmp_capture;
    @(posedge mclk) disable iff (rst)
      (ctl.enable && ctl.mode == TCG_MODE_CAPCMP && started && sel_edge && quiet)
        |=> capture == $past(count) && count == COUNT_RESTART && timer_irq;
  endproperty
  a_capcmp_capture: assert property (p_capcmp_capture) else $error("capcmp capture");

  property p_reload_pair;
    @(posedge mclk) disable iff (rst)
      s_reload_high_write ##1 s_reload_low_idle [*2]
        |-> reload == $past(reload, 2);
  endproperty
  a_reload_pair: assert property (p_reload_pair) else $error("reload changed early");

  property p_hold_latch;
    @(posedge mclk) disable iff (rst)
      (rd_first && idx == IDX_COUNT_HIGH && ctl.enable) |=> low_hold == $past(count[7:0]);
  endproperty
  a_hold_latch: assert property (p_hold_latch) else $error("hold not latched");

  property p_disabled_frozen;
    @(posedge mclk) disable iff (rst)
      (!ctl.enable && quiet) |=> count == $past(count);
  endproperty
  a_disabled_frozen: assert property (p_disabled_frozen) else $error("count moved");
endmodule
`default_nettype wire
